/* File: pri_pkg.sv */
// shared constants and types of the prioritised interrupt controller
package pri_pkg;
  localparam int NUM_SRC  = 16;
  localparam int NUM_TRAP = 8;
  localparam int NUM_REQ  = NUM_TRAP + NUM_SRC;
  localparam int VEC_W    = 5;
  localparam int PRIO_W   = 3;
  localparam int LVL_W    = 4;
  localparam int TDIS_W   = 14;
  localparam int EVT_W    = 4;
  localparam int NEST_BIT = 15;

  // register byte offsets
  localparam logic [11:0] OFF_ICON1   = 12'h000;
  localparam logic [11:0] OFF_FLAGS   = 12'h004;
  localparam logic [11:0] OFF_ENABLE  = 12'h008;
  localparam logic [11:0] OFF_SLB     = 12'h00C;
  localparam logic [11:0] OFF_TDIS    = 12'h010;
  localparam logic [11:0] OFF_EV_STAT = 12'h014;
  localparam logic [11:0] OFF_EV_CLR  = 12'h018;
  localparam logic [11:0] OFF_EV_EN   = 12'h01C;
  localparam logic [11:0] OFF_PRIO0   = 12'h020;
  localparam logic [11:0] OFF_PRIO1   = 12'h024;
  localparam logic [11:0] OFF_PRIO2   = 12'h028;
  localparam logic [11:0] OFF_ERRPRIO = 12'h02C;

  // reset values and level codes
  localparam logic [PRIO_W-1:0]  PRIO_RST  = 3'h4;
  localparam logic [NUM_SRC-1:0] SRC_IMPL  = 16'hEFFF;
  localparam logic [LVL_W-1:0]   TDIS_LVL  = 4'h6;
  localparam logic [LVL_W-1:0]   TRAP_BASE = 4'h8;
  localparam logic [7:0]         SLB_RST   = 8'h00;

  // event status bit positions
  localparam int EV_INT   = 0;
  localparam int EV_TRAP  = 1;
  localparam int EV_OVF   = 2;
  localparam int EV_UNF   = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // return sequencer
  typedef enum logic [1:0] {
    RET_IDLE  = 2'b00,
    RET_FETCH = 2'b01
  } pri_ret_t;
endpackage

/* File: pri_arb.sv */
// highest-level picker over all trap and user requests
`timescale 1ns/1ps
module pri_arb import pri_pkg::*; #(
  parameter int N = NUM_REQ
) (
  input  wire logic [N*LVL_W-1:0] lvl_flat,
  output logic      [LVL_W-1:0]   best_lvl,
  output logic      [VEC_W-1:0]   best_idx
);
  // strict compare keeps the lowest index on a tie
  always_comb begin
    best_lvl = '0;
    best_idx = '0;
    for (int i = 0; i < N; i++) begin
      if (lvl_flat[i*LVL_W +: LVL_W] > best_lvl) begin
        best_lvl = lvl_flat[i*LVL_W +: LVL_W];
        best_idx = VEC_W'(i);
      end
    end
  end
endmodule // pri_arb

/* File: pri_ctx_mem.sv */
// context stack memory with registered read data
`timescale 1ns/1ps
module pri_ctx_mem #(
  parameter int W     = 32,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          core_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [DEPTH];

  // write port
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // pri_ctx_mem

/* File: pri_ctrl.sv */
// prioritised interrupt controller top with AXI4-Lite registers
// Summary of operation
// - crc error priority is 3 bits at 14-12; 7 highest, 0 disables
// - serial1 error priority at bits 6-4, same code; unused bits read 0
// - every implemented user source priority resets to level 4; the field of unimplemented source 12 reads 0
// - nesting_disable bit 15 stops user preemption of a running routine
// - flags stay set until cleared; uncleared flag re-enters after return
// - return restores stacked pc, status_low_byte and old cpu level
// - cpu level 7 in status_low_byte holds off all user sources
// - traps use levels 8-15, served at any cpu level below their own, never masked
// - timed disable masks levels 1-6 for a count; level 7 still passes
// - a source requests only with its enable and its flag both set
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module pri_ctrl import pri_pkg::*; #(
  parameter int PC_W      = 23,
  parameter int CTX_DEPTH = 16
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic      [1:0]         s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic      [31:0]        s_axi_rdata,
  output logic      [1:0]         s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [NUM_SRC-1:0] src_evt,
  input  wire logic [NUM_TRAP-1:0] trap_evt,
  input  wire logic               int_ack,
  input  wire logic [PC_W-1:0]    ack_pc,
  input  wire logic               int_ret,
  input  wire logic               instr_done,
  output logic                    int_req,
  output logic      [VEC_W-1:0]   int_vec,
  output logic      [LVL_W-1:0]   int_lvl,
  output logic                    ret_valid,
  output logic      [PC_W-1:0]    ret_pc,
  output logic      [7:0]         ret_slb,
  output logic      [LVL_W-1:0]   cpu_ipl,
  output logic                    irq
);
  localparam int AW    = $clog2(CTX_DEPTH);
  localparam int CTX_W = PC_W + 9;
  localparam logic [AW:0] DEPTH_MAX = (AW+1)'(CTX_DEPTH);

  // bus side state
  logic              awready_ff, wready_ff, bvalid_ff, arready_ff;
  logic              rvalid_ff, have_aw_ff, have_w_ff;
  logic [1:0]        bresp_ff, rresp_ff;
  logic [11:0]       aw_addr_ff;
  logic [31:0]       w_data_ff, rdata_ff;
  logic [3:0]        w_strb_ff;
  // controller state
  logic [NUM_SRC-1:0]  flag_ff, en_ff;
  logic [NUM_TRAP-1:0] trap_ff;
  logic                nest_dis_ff;
  logic [PRIO_W-1:0]   prio_ff [NUM_SRC];
  logic [7:0]          slb_ff;
  logic                in_trap_ff;
  logic [TDIS_W-1:0]   tdis_cnt_ff;
  logic [AW:0]         depth_ff;
  pri_ret_t            ret_st_ff;
  logic                int_req_ff, ret_valid_ff, irq_ff;
  logic [VEC_W-1:0]    int_vec_ff;
  logic [LVL_W-1:0]    int_lvl_ff;
  logic [PC_W-1:0]     ret_pc_ff;
  logic [7:0]          ret_slb_ff;
  logic [EVT_W-1:0]    ev_st_ff, ev_en_ff, nxt_ev_st, ev_set;
  // combinational
  logic                aw_take, w_take, ar_take, wr_do, wr_ok, rd_ok;
  logic                nxt_have_aw, nxt_have_w, nxt_rvalid;
  logic                ack_take, ret_take, push_ok, req_ok;
  logic [31:0]         wmask, wbits, rd_word;
  logic [NUM_REQ*LVL_W-1:0] lvl_flat;
  logic [NUM_SRC*4-1:0] prio_rd;
  logic [LVL_W-1:0]    best_lvl, ipl_now, thr;
  logic [VEC_W-1:0]    best_idx;
  logic [CTX_W-1:0]    ctx_rd;

  // select of a register on the pending write
  function automatic logic wsel(input logic [11:0] off);
    return wr_do && (aw_addr_ff[11:2] == off[11:2]);
  endfunction

  // write channel handshakes; address and data taken in either order
  assign aw_take     = s_axi_awvalid & awready_ff;
  assign w_take      = s_axi_wvalid & wready_ff;
  assign wr_do       = have_aw_ff & have_w_ff & ~bvalid_ff;
  assign nxt_have_aw = (have_aw_ff & ~wr_do) | aw_take;
  assign nxt_have_w  = (have_w_ff & ~wr_do) | w_take;
  assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                  {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  assign wbits = w_data_ff & wmask;

  // write address and data holding
  always_ff @(posedge core_clk) begin
    if (rst) begin
      have_aw_ff <= 1'b0;
      have_w_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else begin
      have_aw_ff <= nxt_have_aw;
      have_w_ff  <= nxt_have_w;
      awready_ff <= ~nxt_have_aw;
      wready_ff  <= ~nxt_have_w;
      if (aw_take) begin
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
    end
  end

  // write map check
  always_comb begin
    case ({aw_addr_ff[11:2], 2'b00})
      OFF_ICON1, OFF_FLAGS, OFF_ENABLE, OFF_SLB, OFF_TDIS,
      OFF_EV_STAT, OFF_EV_CLR, OFF_EV_EN, OFF_PRIO0, OFF_PRIO1,
      OFF_PRIO2, OFF_ERRPRIO: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read data mux
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[11:2], 2'b00})
      OFF_ICON1: begin
        rd_word[NEST_BIT]       = nest_dis_ff;
        rd_word[NUM_TRAP-1:0]   = trap_ff;
      end
      OFF_FLAGS:   rd_word[NUM_SRC-1:0] = flag_ff;
      OFF_ENABLE:  rd_word[NUM_SRC-1:0] = en_ff;
      OFF_SLB:     rd_word[8:0]         = {in_trap_ff, slb_ff};
      OFF_TDIS:    rd_word[TDIS_W-1:0]  = tdis_cnt_ff;
      OFF_EV_STAT: rd_word[EVT_W-1:0]   = ev_st_ff;
      OFF_EV_CLR:  rd_word              = 32'h0000_0000;
      OFF_EV_EN:   rd_word[EVT_W-1:0]   = ev_en_ff;
      OFF_PRIO0:   rd_word[15:0]        = prio_rd[15:0];
      OFF_PRIO1:   rd_word[15:0]        = prio_rd[31:16];
      OFF_PRIO2:   rd_word[15:0]        = prio_rd[47:32];
      OFF_ERRPRIO: rd_word[15:0]        = prio_rd[63:48];
      default:     rd_ok                = 1'b0;
    endcase
  end

  // read channel, answer one cycle after the address is taken
  assign ar_take    = s_axi_arvalid & arready_ff;
  assign nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // per-source priority fields, flag and enable gating
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    localparam int R = i / 4;
    localparam int K = i % 4;
    always_ff @(posedge core_clk) begin
      if (rst) begin
        prio_ff[i] <= PRIO_RST;
      end else if (wsel(OFF_PRIO0 + 12'(4*R)) && w_strb_ff[K/2]) begin
        prio_ff[i] <= w_data_ff[4*K +: PRIO_W];
      end
    end
    // unimplemented fields and the spare bit of each nibble read zero
    assign prio_rd[4*i +: 4] = SRC_IMPL[i] ? {1'b0, prio_ff[i]} : 4'h0;
    // zero priority disables; request needs flag and enable
    assign lvl_flat[(NUM_TRAP+i)*LVL_W +: LVL_W] =
      (flag_ff[i] && en_ff[i] && SRC_IMPL[i]) ?
      {1'b0, prio_ff[i]} : 4'h0;
  end

  // traps sit on levels 8 to 15 with no enable
  for (genvar j = 0; j < NUM_TRAP; j++) begin : g_trap
    assign lvl_flat[j*LVL_W +: LVL_W] =
      trap_ff[j] ? (TRAP_BASE | LVL_W'(j)) : 4'h0;
  end

  pri_arb #(
    .N (NUM_REQ)
  ) u_arb (
    .lvl_flat (lvl_flat),
    .best_lvl (best_lvl),
    .best_idx (best_idx)
  );

  // source flags: hardware set wins over the software clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= (flag_ff & ~(wsel(OFF_FLAGS) ?
                 wbits[NUM_SRC-1:0] : '0)) | (src_evt & SRC_IMPL);
    end
  end

  // trap flags and nesting control
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trap_ff     <= '0;
      nest_dis_ff <= 1'b0;
    end else begin
      trap_ff <= (trap_ff & ~(wsel(OFF_ICON1) ?
                 wbits[NUM_TRAP-1:0] : '0)) | trap_evt;
      if (wsel(OFF_ICON1) && w_strb_ff[1]) begin
        nest_dis_ff <= w_data_ff[NEST_BIT];
      end
    end
  end

  // source enables
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_ff <= '0;
    end else if (wsel(OFF_ENABLE)) begin
      en_ff <= (en_ff & ~wmask[NUM_SRC-1:0]) | wbits[NUM_SRC-1:0];
    end
  end

  // timed disable window, counted down on retired instructions
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tdis_cnt_ff <= '0;
    end else if (wsel(OFF_TDIS)) begin
      tdis_cnt_ff <= w_data_ff[TDIS_W-1:0];
    end else if (instr_done && tdis_cnt_ff != '0) begin
      tdis_cnt_ff <= tdis_cnt_ff - 1'b1;
    end
  end

  // acceptance threshold from cpu level and the timed window
  assign ipl_now = {in_trap_ff, slb_ff[7:5]};
  assign thr = (tdis_cnt_ff != '0 && ipl_now < TDIS_LVL) ?
               TDIS_LVL : ipl_now;
  assign req_ok = (best_lvl > thr)
                && !(nest_dis_ff && depth_ff != '0
                     && best_lvl < TRAP_BASE)
                && ret_st_ff == RET_IDLE && !int_ack && !int_ret;
  assign ack_take = int_ack & int_req_ff;
  assign ret_take = int_ret & ~int_ack & (ret_st_ff == RET_IDLE)
                  & (depth_ff != '0);
  assign push_ok  = ack_take & (depth_ff != DEPTH_MAX);

  // request presented to the core; vector and level held beside it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_req_ff <= 1'b0;
      int_vec_ff <= '0;
      int_lvl_ff <= '0;
    end else begin
      int_req_ff <= req_ok;
      int_vec_ff <= best_idx;
      int_lvl_ff <= best_lvl;
    end
  end

  // saved contexts: pc, status byte and trap level bit
  pri_ctx_mem #(
    .W     (CTX_W),
    .DEPTH (CTX_DEPTH)
  ) u_ctx (
    .core_clk (core_clk),
    .wr_en    (push_ok),
    .wr_addr  (depth_ff[AW-1:0]),
    .wr_data  ({ack_pc, slb_ff, in_trap_ff}),
    .rd_en    (ret_take),
    .rd_addr  (AW'(depth_ff - 1'b1)),
    .rd_data  (ctx_rd)
  );

  // stack depth
  always_ff @(posedge core_clk) begin
    if (rst) begin
      depth_ff <= '0;
    end else if (push_ok) begin
      depth_ff <= depth_ff + 1'b1;
    end else if (ret_take) begin
      depth_ff <= depth_ff - 1'b1;
    end
  end

  // return sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ret_st_ff <= RET_IDLE;
    end else begin
      case (ret_st_ff)
        RET_IDLE:  ret_st_ff <= ret_take ? RET_FETCH : RET_IDLE;
        RET_FETCH: ret_st_ff <= RET_IDLE;
        default:   ret_st_ff <= RET_IDLE;
      endcase
    end
  end

  // cpu level: restore on return, raise on entry, else software
  always_ff @(posedge core_clk) begin
    if (rst) begin
      slb_ff     <= SLB_RST;
      in_trap_ff <= 1'b0;
    end else if (ret_st_ff == RET_FETCH) begin
      slb_ff     <= ctx_rd[8:1];
      in_trap_ff <= ctx_rd[0];
    end else if (ack_take) begin
      slb_ff[7:5] <= int_lvl_ff[2:0];
      in_trap_ff  <= int_lvl_ff[3];
    end else if (wsel(OFF_SLB) && w_strb_ff[0]) begin
      slb_ff <= w_data_ff[7:0];
    end
  end

  // restored context handed back to the core
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ret_valid_ff <= 1'b0;
      ret_pc_ff    <= '0;
      ret_slb_ff   <= 8'h00;
    end else begin
      ret_valid_ff <= (ret_st_ff == RET_FETCH);
      if (ret_st_ff == RET_FETCH) begin
        ret_pc_ff  <= ctx_rd[CTX_W-1:9];
        ret_slb_ff <= ctx_rd[8:1];
      end
    end
  end

  // block events
  always_comb begin
    ev_set          = '0;
    ev_set[EV_INT]  = ack_take & ~int_lvl_ff[3];
    ev_set[EV_TRAP] = ack_take & int_lvl_ff[3];
    ev_set[EV_OVF]  = ack_take & ~push_ok;
    ev_set[EV_UNF]  = int_ret & ~int_ack & (ret_st_ff == RET_IDLE)
                    & (depth_ff == '0);
  end
  assign nxt_ev_st = (ev_st_ff & ~(wsel(OFF_EV_CLR) ?
                     wbits[EVT_W-1:0] : '0)) | ev_set;

  // sticky event status, enable and interrupt line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ev_st_ff <= '0;
      ev_en_ff <= '0;
      irq_ff   <= 1'b0;
    end else begin
      ev_st_ff <= nxt_ev_st;
      if (wsel(OFF_EV_EN)) begin
        ev_en_ff <= w_data_ff[EVT_W-1:0];
      end
      irq_ff <= |(nxt_ev_st & (wsel(OFF_EV_EN) ?
                w_data_ff[EVT_W-1:0] : ev_en_ff));
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign int_req       = int_req_ff;
  assign int_vec       = int_vec_ff;
  assign int_lvl       = int_lvl_ff;
  assign ret_valid     = ret_valid_ff;
  assign ret_pc        = ret_pc_ff;
  assign ret_slb       = ret_slb_ff;
  assign cpu_ipl       = {in_trap_ff, slb_ff[7:5]};
  assign irq           = irq_ff;
endmodule // pri_ctrl

/* File: pri_core_model.sv */
// stand-in core: takes vectors after a wait, returns on command
`timescale 1ns/1ps
module pri_core_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        int_req,
  input  wire logic        take,
  input  wire logic [3:0]  ack_wait,
  input  wire logic        go_ret,
  output logic             int_ack,
  output logic      [22:0] ack_pc,
  output logic             int_ret
);
  logic [3:0]  wait_ff;
  logic [22:0] pc_ff;
  logic        nxt_ack;

  // ack a standing request, never beside a return; re-takes a left flag
  assign nxt_ack = int_req && take && !int_ack && !go_ret &&
                   wait_ff >= ack_wait;
  // pc is valid only beside the ack, junk otherwise
  assign ack_pc = int_ack ? pc_ff : ~pc_ff;

  // wait counter runs while a request stands
  always_ff @(posedge core_clk) begin
    if (rst || !int_req)
      wait_ff <= 4'h0;
    else if (wait_ff != 4'hF)
      wait_ff <= wait_ff + 4'h1;
  end

  // ack pulse, pc moves on once the ack is taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_ack <= 1'b0;
      pc_ff   <= 23'h000100;
    end else begin
      int_ack <= nxt_ack;
      if (int_ack && int_req)
        pc_ff <= pc_ff + 23'h000004;
    end
  end

  // return pulse when the handler is finished
  always_ff @(posedge core_clk) begin
    if (rst)
      int_ret <= 1'b0;
    else
      int_ret <= go_ret;
  end
endmodule // pri_core_model

/* File: pri_ctrl_sva.sv */
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
module pri_ctrl_sva import pri_pkg::*; (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             int_ack,
  input wire logic             int_ret,
  input wire logic             int_req,
  input wire logic [VEC_W-1:0] int_vec,
  input wire logic [LVL_W-1:0] int_lvl,
  input wire logic             ret_valid,
  input wire logic [LVL_W-1:0] cpu_ipl,
  input wire logic             irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_trap_lvl: assert property (int_req && int_vec < 5'h08 |->
    int_lvl == {1'b1, int_vec[2:0]}) else $error("trap level wrong");
  chk_user_lvl: assert property (int_req && int_vec >= 5'h08 |->
    int_vec <= 5'h17 && int_lvl inside {[1:7]})
    else $error("user level out of range");
  chk_user_ipl: assert property (int_req && int_vec >= 5'h08 |->
    int_lvl > $past(cpu_ipl) || int_lvl > cpu_ipl)
    else $error("user request not above cpu level");
  chk_ack_entry: assert property (int_req && int_ack |=>
    !int_req && cpu_ipl == $past(int_lvl)) else $error("entry wrong");
  chk_ret_src: assert property (ret_valid |->
    $past(int_ret, 2) && !$past(int_ack, 2)) else $error("stray return");
  chk_ret_quiet: assert property (int_ret && !int_ack |=>
    !int_req) else $error("request during return");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");

  cov_ret: cover property (ret_valid);
  cov_trap: cover property (int_req && int_vec < 5'h08);
  cov_irq: cover property (irq);
endmodule // pri_ctrl_sva

bind pri_ctrl pri_ctrl_sva i_pri_ctrl_sva (
  .core_clk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .int_ack, .int_ret,
  .int_req, .int_vec, .int_lvl, .ret_valid, .cpu_ipl, .irq);

/* File: tb.sv */
// self-checking bench of the prioritised interrupt controller
`timescale 1ns/1ps
module tb import pri_pkg::*;;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, w;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] src_evt = '0, en, fl;
  logic [7:0]  trap_evt = '0, ret_slb;
  logic        take = 0, go_ret = 0, instr_done = 0;
  logic        int_ack, int_ret, int_req, ret_valid, irq;
  logic [22:0] ack_pc, ret_pc;
  logic [4:0]  int_vec, ack_vec;
  logic [3:0]  int_lvl, cpu_ipl, ack_lvl, lv, ack_wait = '0;
  logic [26:0] stk[$];
  logic [2:0]  pr[16];
  int          num_errors = 0, n_tests = 0, n_ack = 0, it, r, k;

  always #2.5 core_clk = ~core_clk;

  pri_ctrl i_pri_ctrl (
    .core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .src_evt, .trap_evt, .int_ack, .ack_pc,
    .int_ret, .instr_done, .int_req, .int_vec, .int_lvl, .ret_valid,
    .ret_pc, .ret_slb, .cpu_ipl, .irq);
  pri_core_model i_pri_core_model (
    .core_clk, .rst, .int_req, .take, .ack_wait, .go_ret, .int_ack,
    .ack_pc, .int_ret);

  task automatic cmp(input string s, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic test_done;
    $display("errors %0d in %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic tmo;
    num_errors++;
    test_done();
  endtask

  // stack each taken context, check it on the restore
  always @(posedge core_clk) begin
    if (!rst && int_req && int_ack) begin
      stk.push_back({ack_pc, cpu_ipl});
      ack_vec <= int_vec;
      ack_lvl <= int_lvl;
      n_ack <= n_ack + 1;
    end
    if (!rst && ret_valid) begin
      cmp("ret_pc", 32'(stk[$][26:4]), 32'(ret_pc));
      cmp("ret_ipl", 32'(stk[$][3:0]), 32'(cpu_ipl));
      cmp("ret_slb", 32'(stk[$][2:0]), 32'(ret_slb[7:5]));
      void'(stk.pop_back());
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) tmo();
    cmp("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) tmo();
    cmp("rdata", ed, s_axi_rdata);
    cmp("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic evt(input logic [15:0] s, input logic [7:0] t);
    @(posedge core_clk);
    src_evt <= s;
    trap_evt <= t;
    @(posedge core_clk);
    src_evt <= '0;
    trap_evt <= '0;
  endtask

  task automatic pulses(input int n);
    repeat (2 * n) begin
      @(posedge core_clk);
      instr_done <= ~instr_done;
    end
  endtask

  // e is {request, vector, level}
  task automatic chk_req(input logic [9:0] e);
    @(posedge core_clk);
    cmp("int_req", 32'(e[9]), 32'(int_req));
    if (e[9]) cmp("vec_lvl", 32'(e[8:0]), 32'({int_vec, int_lvl}));
  endtask

  task automatic wait_ack(input logic [4:0] ev);
    int n, c;
    c = n_ack;
    for (n = 0; n < 60 && n_ack == c; n++) @(posedge core_clk);
    if (n == 60) tmo();
    cmp("ack_vec", 32'(ev), 32'(ack_vec));
  endtask

  task automatic ret;
    int n;
    @(posedge core_clk);
    go_ret <= 1'b1;
    @(posedge core_clk);
    go_ret <= 1'b0;
    for (n = 0; n < 20 && ret_valid !== 1'b1; n++) @(posedge core_clk);
    if (n == 20) tmo();
  endtask

  task automatic irq_step(input logic [11:0] a, input logic [31:0] d,
                          input logic e);
    wr(a, d);
    cyc(2);
    cmp("irq", 32'(e), 32'(irq));
  endtask

  // winner among flagged, enabled sources above the threshold
  function automatic logic [9:0] best(input logic [15:0] f, e,
                                      input logic [3:0] thr);
    logic [3:0] bl;
    logic [4:0] bv;
    bl = thr;
    bv = '0;
    for (int i = 0; i < NUM_SRC; i++)
      if (f[i] && e[i] && SRC_IMPL[i] && {1'b0, pr[i]} > bl) begin
        bl = {1'b0, pr[i]};
        bv = 5'(i + 8);
      end
    return {bl > thr, bv, bl};
  endfunction

  // reset, register defaults, random arbitration, then corner cases
  initial begin
    void'($urandom(32'h0A94));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (r = 0; r < 3; r++) rd(OFF_PRIO0 + 12'(4 * r), 32'h4444);
    rd(OFF_ERRPRIO, 32'h4440);
    rd(12'h0F0, 32'h0, RESP_SLVERR);
    wr(12'h0F0, 32'h1, RESP_SLVERR);
    for (it = 0; it < 40; it++) begin
      for (r = 0; r < 4; r++) begin
        w = (it == 0 ? 32'hFFFF : $urandom) & (r == 3 ? 32'h7770 : 32'h7777);
        wr(OFF_PRIO0 + 12'(4 * r), w);
        rd(OFF_PRIO0 + 12'(4 * r), w);
        for (k = 0; k < 4; k++) pr[4 * r + k] = w[4 * k +: 3];
      end
      en = it == 0 ? 16'hFFFF : 16'($urandom);
      fl = it == 0 ? 16'hFFFF : 16'($urandom);
      lv = it == 0 ? 4'h0 : 4'($urandom_range(7));
      wr(OFF_ENABLE, {16'h0, en});
      wr(OFF_SLB, {24'h0, lv[2:0], 5'h0});
      evt(fl, 8'h0);
      cyc(3);
      chk_req(best(fl, en, lv));
      cmp("cpu_ipl", 32'(lv), 32'(cpu_ipl));
      wr(OFF_FLAGS, 32'hFFFF);
    end
    for (r = 0; r < 4; r++) wr(OFF_PRIO0 + 12'(4 * r), r == 0 ? 32'h53 : 0);
    wr(OFF_SLB, 32'h0);
    wr(OFF_ENABLE, 32'h3);
    wr(OFF_EV_EN, 32'h1);
    take <= 1'b1;
    ack_wait <= 4'($urandom_range(6));
    evt(16'h1, 8'h0);
    wait_ack(5'h08);
    cyc(3);
    cmp("irq", 32'h1, 32'(irq));
    irq_step(OFF_EV_EN, 32'h0, 1'b0);
    irq_step(OFF_EV_EN, 32'h1, 1'b1);
    irq_step(OFF_EV_CLR, 32'h1, 1'b0);
    wr(OFF_ICON1, 32'h8000);
    evt(16'h2, 8'h0);
    repeat (6) chk_req(10'h0);
    wr(OFF_ICON1, 32'h0);
    wait_ack(5'h09);
    wr(OFF_FLAGS, 32'h2);
    ret();
    ret();
    wait_ack(5'h08);
    wr(OFF_FLAGS, 32'h1);
    ret();
    repeat (4) chk_req(10'h0);
    wr(OFF_SLB, 32'hE0);
    evt(16'h1, 8'h4);
    wait_ack(5'h02);
    cmp("trap_lvl", 32'hA, 32'(ack_lvl));
    wr(OFF_ICON1, 32'h4);
    ret();
    repeat (4) chk_req(10'h0);
    take <= 1'b0;
    wr(OFF_SLB, 32'h0);
    wr(OFF_PRIO0, 32'h76);
    wr(OFF_FLAGS, 32'hFFFF);
    wr(OFF_TDIS, 32'h5);
    evt(16'h1, 8'h0);
    cyc(3);
    chk_req(10'h0);
    evt(16'h2, 8'h0);
    cyc(3);
    chk_req({1'b1, 5'h09, 4'h7});
    wr(OFF_FLAGS, 32'h2);
    pulses(4);
    cyc(2);
    chk_req(10'h0);
    pulses(1);
    cyc(3);
    chk_req({1'b1, 5'h08, 4'h6});
    test_done();
  end
endmodule // tb
